// >>> common/kfw_pkg.sv
package kfw_pkg;
  // register byte addresses on the avalon slave (word aligned)
  localparam logic [3:0] KFW_ADDR_CTRL = 4'h0;
  localparam logic [3:0] KFW_ADDR_RELOAD = 4'h4;
  localparam logic [3:0] KFW_ADDR_KEY1 = 4'h8;
  localparam logic [3:0] KFW_ADDR_KEY2 = 4'hC;
  // feed keys
  localparam logic [7:0] KFW_KEY_FIRST = 8'hA5;
  localparam logic [7:0] KFW_KEY_SECOND = 8'h5A;
  // control register layout
  localparam int KFW_PRE_LSB = 5;
  localparam int KFW_RUN_BIT = 2;
  localparam int KFW_TOF_BIT = 1;
  localparam logic [7:0] KFW_CTRL_RST = 8'hE4;
  localparam logic [7:0] KFW_CTRL_WDRST = 8'hE6;
  localparam logic [7:0] KFW_CTRL_WMASK = 8'hE4;
  localparam logic [7:0] KFW_RELOAD_RST = 8'h00;
  // prescaler geometry
  localparam int KFW_PRE_W = 13;
  localparam int KFW_CNT_W = 8;
  localparam int KFW_TAP_BASE = 4;
  localparam logic [2:0] KFW_PRE_MAX = 3'h7;
  // timer tick divisor from oscillator
  localparam int KFW_TICK_DIV = 4;
  localparam logic [1:0] KFW_TICK_LAST = 2'h3;
endpackage : kfw_pkg

// >>> logic/kfw_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
// shared timer tick: one pulse every KFW_TICK_DIV clocks
module kfw_tick_gen
  import kfw_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  output logic tick_o
);
  logic [1:0] div_q;
  wire last_w = (div_q == KFW_TICK_LAST);

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      div_q <= 2'h0;
      tick_o <= 1'b0;
    end
    else
    begin
      div_q <= div_q + 2'h1;
      tick_o <= last_w;
    end
  end
endmodule : kfw_tick_gen
`default_nettype wire

// >>> logic/kfw_watchdog.sv
// Summary of operation
// - watchdog runs after every reset
// - 13-bit prescaler feeding 8-bit down-counter
// - prescaler advanced by shared timer tick
// - counter decrements on upper prescaler tap
// - select code picks divisor 32 to 4096
// - decrement at zero: underflow reset, reload
// - any reload value; autoload clears prescaler
// - timeout is tick times divisor times W+1
// - counter only loadable through feed, a watchdog reset autoload or external reset (00)
// - feed is A5 then 5A as next access
// - bad second key gives immediate reset
// - other access between keys gives reset
// - control writes pend until valid feed
// - stop: write zero control, then feed
// - reset state gives running 4x4096 timeout
// - external reset initialises run, reload, prescaler
// - underflow at external reset leaves flag clear
// - control resets E6 after watchdog, else E4
//
// Our own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module kfw_watchdog
  import kfw_pkg::*;
#(
  parameter int PRE_W = KFW_PRE_W,
  parameter int CNT_W = KFW_CNT_W
)
(
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic wdt_reset_o
);
  // one-hot so that a flipped state bit decodes as illegal
  typedef enum logic [1:0]
  {
    KFW_FEED_IDLE = 2'h1,
    KFW_FEED_ARMED = 2'h2
  } kfw_feed_t;

  logic tick_w;
  logic [PRE_W-1:0] pre_q;
  logic [CNT_W-1:0] cnt_q;
  logic [7:0] reload_q;
  logic [7:0] ctrl_pend_q;
  logic [2:0] pre_sel_q;
  logic run_q;
  logic tof_q;
  kfw_feed_t feed_q;
  kfw_feed_t feed_d;
  logic tap_prev_q;
  logic ack_q;
  logic waitreq_q;
  logic wdt_reset_q;
  logic [31:0] rdata_q;

  // same tick that clocks the general timers
  kfw_tick_gen u_tick (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .tick_o(tick_w)
  );

  // one wait state: access accepted on the edge where ack_q is high
  wire req_w = (avs_read_i | avs_write_i) & ~ack_q;
  wire acc_w = (avs_read_i | avs_write_i) & ack_q;
  wire wr_w = avs_write_i & ack_q & avs_byteenable_i[0];
  wire [7:0] wbyte_w = avs_writedata_i[7:0];
  wire hit_ctrl_w = (avs_address_i == KFW_ADDR_CTRL);
  wire hit_reload_w = (avs_address_i == KFW_ADDR_RELOAD);
  wire hit_key1_w = (avs_address_i == KFW_ADDR_KEY1);
  wire hit_key2_w = (avs_address_i == KFW_ADDR_KEY2);
  wire key1_good_w = wr_w & hit_key1_w & (wbyte_w == KFW_KEY_FIRST);
  wire key2_wr_w = wr_w & hit_key2_w;
  wire key1_ok_w = (feed_q == KFW_FEED_ARMED);
  // second key must be the very next access
  wire feed_w = key1_ok_w & key2_wr_w & (wbyte_w == KFW_KEY_SECOND);
  // any other access while armed is fatal
  wire key_fail_w = key1_ok_w & acc_w & ~feed_w;

  // tap bit KFW_TAP_BASE+sel gives divisor 32 << sel
  wire [3:0] tap_idx_w = 4'(KFW_TAP_BASE) + {1'b0, pre_sel_q};
  wire tap_w = pre_q[tap_idx_w];
  wire dec_w = run_q & tap_prev_q & ~tap_w;
  wire underflow_w = dec_w & (cnt_q == '0);
  wire fire_w = underflow_w | key_fail_w;
  // every watchdog reset also autoloads the counter
  wire autoload_w = feed_w | fire_w;

  wire [7:0] ctrl_rd_w = {pre_sel_q, 2'h0, run_q, tof_q, 1'b0};
  wire [7:0] rd_mux_w =
    hit_ctrl_w ? ctrl_rd_w :
    hit_reload_w ? reload_q : 8'h00;

  // prescaler counts ticks only while running
  wire [PRE_W-1:0] pre_inc_w = pre_q + 1'b1;
  wire [PRE_W-1:0] pre_d =
    autoload_w ? '0 :
    (run_q & tick_w) ? pre_inc_w : pre_q;

  // the reload register is the only source of a new count
  wire [CNT_W-1:0] cnt_dec_w = cnt_q - 1'b1;
  wire [CNT_W-1:0] cnt_d =
    autoload_w ? CNT_W'(reload_q) :
    dec_w ? cnt_dec_w : cnt_q;

  // edge detector freezes with the prescaler, no false edge
  wire tap_prev_d =
    autoload_w ? 1'b0 :
    run_q ? tap_w : tap_prev_q;

  // control writes only park in the pending copy
  wire ctrl_wr_w = wr_w & hit_ctrl_w;
  wire reload_wr_w = wr_w & hit_reload_w;
  wire [7:0] ctrl_pend_d =
    fire_w ? KFW_CTRL_RST :
    ctrl_wr_w ? (wbyte_w & KFW_CTRL_WMASK) : ctrl_pend_q;
  // any byte is a legal reload value
  wire [7:0] reload_d = reload_wr_w ? wbyte_w : reload_q;

  // a watchdog reset restores run and the largest divisor
  // otherwise the pending control applies only on a feed
  wire run_d =
    fire_w ? 1'b1 :
    feed_w ? ctrl_pend_q[KFW_RUN_BIT] : run_q;
  wire [2:0] pre_sel_d =
    fire_w ? KFW_PRE_MAX :
    feed_w ? ctrl_pend_q[KFW_PRE_LSB +: 3] : pre_sel_q;

  // sticky: software cannot clear it, only an external reset
  wire tof_d = tof_q | fire_w;
  wire [31:0] rdata_d =
    (req_w & avs_read_i) ? {24'h0, rd_mux_w} : rdata_q;

  // arm on a correct first key; the next access disarms
  always_comb
  begin
    feed_d = feed_q;
    unique case (feed_q)
      KFW_FEED_IDLE:
      begin
        if (key1_good_w & ~fire_w)
          feed_d = KFW_FEED_ARMED;
      end
      KFW_FEED_ARMED:
      begin
        if (acc_w | fire_w)
          feed_d = KFW_FEED_IDLE;
      end
      default:
        feed_d = KFW_FEED_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pre_q <= '0;
    end
    else
    begin
      pre_q <= pre_d; // cleared on autoload
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt_q <= CNT_W'(KFW_RELOAD_RST); // autoload of 00
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tap_prev_q <= 1'b0;
    end
    else
    begin
      tap_prev_q <= tap_prev_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      reload_q <= KFW_RELOAD_RST;
    end
    else
    begin
      reload_q <= reload_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctrl_pend_q <= KFW_CTRL_RST;
    end
    else
    begin
      ctrl_pend_q <= ctrl_pend_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pre_sel_q <= KFW_PRE_MAX;
    end
    else
    begin
      pre_sel_q <= pre_sel_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      run_q <= 1'b1;
    end
    else
    begin
      run_q <= run_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tof_q <= 1'b0; // reset beats a coincident underflow
    end
    else
    begin
      tof_q <= tof_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      feed_q <= KFW_FEED_IDLE;
    end
    else
    begin
      feed_q <= feed_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= req_w;
    end
  end

  // own flop so the output needs no inverter after the register
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      waitreq_q <= 1'b1;
    end
    else
    begin
      waitreq_q <= ~req_w;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_q <= '0;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wdt_reset_q <= 1'b0;
    end
    else
    begin
      wdt_reset_q <= fire_w;
    end
  end

  assign avs_waitrequest_o = waitreq_q;
  assign avs_readdata_o = rdata_q;
  assign wdt_reset_o = wdt_reset_q;
endmodule : kfw_watchdog
`default_nettype wire

// >>> testbench/kfw_watchdog_props.sv
`timescale 1ns/1ps
`default_nettype none
module kfw_watchdog_props
  import kfw_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic wdt_reset_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  wire acc = (avs_read_i | avs_write_i) & !avs_waitrequest_o;
  wire k2 = avs_write_i & (avs_address_i == KFW_ADDR_KEY2);
  wire ok2 = k2 & (avs_writedata_i[7:0] == KFW_KEY_SECOND);
  wire k1 = avs_write_i & (avs_address_i == KFW_ADDR_KEY1);
  wire ok1 = k1 & (avs_writedata_i[7:0] == KFW_KEY_FIRST);
  // armed after an accepted first key; any next accepted access decides
  logic arm_q;
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
    if (!arst_n_i) arm_q <= 1'b0;
    else if (acc) arm_q <= ok1 & !arm_q;
  wait_one_a: assert property ($rose(avs_read_i | avs_write_i)
    |=> !avs_waitrequest_o) else $error("no answer after one wait");
  wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  bad_key_a: assert property (acc && arm_q && k2 && !ok2
    |=> wdt_reset_o) else $error("bad second key gave no reset");
  other_acc_a: assert property (acc && arm_q && !k2
    |=> wdt_reset_o) else $error("access between keys gave no reset");
  feed_quiet_a: assert property (acc && arm_q && ok2
    |=> (!wdt_reset_o) [*8]) else $error("reset right after feed");
  rst_pulse_a: assert property (wdt_reset_o |=> !wdt_reset_o)
    else $error("reset pulse too long");
  rdata_hi_a: assert property (!avs_waitrequest_o
    |-> avs_readdata_o[31:8] == 24'h0) else $error("upper read bits set");
  rst_clear_a: assert property ($rose(arst_n_i) |-> !wdt_reset_o)
    else $error("reset pulse at reset release");
  cover property (acc && arm_q && ok2);
  cover property (acc && arm_q && !k2);
  cover property (wdt_reset_o);
endmodule : kfw_watchdog_props
bind kfw_watchdog kfw_watchdog_props i_kfw_watchdog_props (.*);
`default_nettype wire

// >>> testbench/kfw_watchdog_tb.sv
`timescale 1ns/1ps
`default_nettype none
module kfw_watchdog_tb
  import kfw_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic wdt_reset_o;
  logic [31:0] q;
  int error_cnt = 0;
  int cmp_count = 0;
  int seed = 32'h3e937d66;
  int w;
  initial forever #2 ref_clk_i = ~ref_clk_i;
  kfw_watchdog i_kfw_watchdog (.*, .avs_byteenable_i(4'hF));
  function automatic int tmo(input int s, input int v);
    return KFW_TICK_DIV * (32 << s) * (v + 1);
  endfunction : tmo
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %0h got %0h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= {24'h0, d};
    do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus
  task automatic feed;
    bus(1'b1, KFW_ADDR_KEY1, KFW_KEY_FIRST);
    bus(1'b1, KFW_ADDR_KEY2, KFW_KEY_SECOND); // nothing between
  endtask : feed
  // counts cycles up to the reset pulse; small slack for bus latency
  task automatic wrst(input string nm, input int e);
    int n;
    n = 0;
    do @(negedge ref_clk_i); while (wdt_reset_o !== 1'b1 && ++n < e + 16);
    chk(nm, e, (n > e - 16 && n < e + 16) ? e : n);
  endtask : wrst
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  initial
  begin
    #320000;
    error_cnt++;
    test_done;
  end
  initial
  begin
    repeat (16) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    bus(1'b0, KFW_ADDR_CTRL, 8'h00);
    chk("ctrl", KFW_CTRL_RST, q);
    bus(1'b0, KFW_ADDR_RELOAD, 8'h00);
    chk("reload", KFW_RELOAD_RST, q);
    wrst("boot", tmo(7, 0));
    bus(1'b0, KFW_ADDR_CTRL, 8'h00);
    chk("flag", KFW_CTRL_WDRST, q);
    $display("end reset");
    for (int s = 0; s < 8; s++)
    begin
      w = (s < 2) ? $random(seed) & 3 : 0;
      bus(1'b1, KFW_ADDR_RELOAD, w[7:0]);
      bus(1'b1, KFW_ADDR_CTRL, {s[2:0], 5'h04});
      bus(1'b0, KFW_ADDR_CTRL, 8'h00);
      chk("pend", KFW_CTRL_WDRST, q);
      feed;
      wrst("tmo", tmo(s, w));
    end
    $display("end select");
    bus(1'b1, KFW_ADDR_KEY1, KFW_KEY_FIRST);
    w = $random(seed);
    bus(1'b1, KFW_ADDR_KEY2, (w[7:0] == KFW_KEY_SECOND) ? 8'h00 : w[7:0]);
    wrst("key2", 1);
    bus(1'b1, KFW_ADDR_KEY1, KFW_KEY_FIRST);
    bus(1'b0, KFW_ADDR_RELOAD, 8'h00);
    wrst("between", 1);
    $display("end keys");
    bus(1'b1, KFW_ADDR_CTRL, 8'h00);
    feed;
    w = 0;
    repeat (700) @(negedge ref_clk_i) w += (wdt_reset_o !== 1'b0);
    chk("stop", 0, w);
    bus(1'b0, KFW_ADDR_CTRL, 8'h00);
    chk("stopctl", 8'h02, q);
    $display("end stop");
    arst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    bus(1'b0, KFW_ADDR_CTRL, 8'h00);
    chk("rst2", KFW_CTRL_RST, q);
    $display("end rearm");
    test_done;
  end
endmodule : kfw_watchdog_tb
`default_nettype wire
